// *** rtl/sysref_out_ctrl.sv ***
// Output state machine, delay lines and APB register file for the clock and SYSREF output stages.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps

// What this block does
// - SYSREF settings only when function select set
// - Function select clear: shared output acts as clock
// - Power down per channel and per clock output
// - Every output has its own enable
// - Every output has its own amplitude field
// - State machine governs SYSREF output on/off
// - Event start turns participating SYSREF outputs on
// - Event end turns SYSREF outputs off
// - Line bias holds powered-off legs at midpoint
// - Line bias midpoint only with bias-style one; in style 0 the leg stays off and low
// - Style 0: static low, toggle, static low
// - Style 1: crosspoint, toggle, back to crosspoint
// - Counted pulses stop then outputs power down
// - Separate delay settings for clock and SYSREF
// - Bypass times all delays from VCXO
// - Clock delay 256 unit steps, edges aligned
// - Coarse SYSREF delay 8 steps on clock edge
// - Fine SYSREF delay eight selectable settings
// - Global SYSREF delay 256 double-unit steps
// - Combined delays give twelve-plus edge positions
module sysref_out_ctrl
  import sysref_out_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output out_s [NUM_CLK_OUT-1:0] clock_output,
  output out_s [NUM_REF_OUT-1:0] sysref_output
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic second_pll_bypass_r;
  logic bias_type_r;
  logic continuous_r;
  logic [NUM_CHAN-1:0] chan_pd_r;
  logic [NUM_REF_OUT-1:0] output_function_select_r;
  logic [NUM_REF_OUT-1:0] line_bias_enable_r;
  logic [31:0] clk_out_cfg_r;
  logic [31:0] ref_out_cfg_r;
  logic [7:0] pulse_cnt_r;
  logic [NS_W-1:0] ref_div_r;
  logic [7:0] global_dly_r;
  logic [NUM_REF_OUT*DLY3_W-1:0] ref_coarse_r;
  logic [NUM_REF_OUT*DLY3_W-1:0] ref_fine_r;
  logic [NUM_CHAN*CDLY_W-1:0] clk_dly_r;
  logic [NUM_CHAN*CDIV_W-1:0] clk_div_r;
  logic release_r;
  logic resync_r;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic [31:0] rd_data;
  sr_state_e state_r;
  logic [7:0] remain_r;
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && !pready;
  always_comb begin
    addr_hit = 1'b1;
    rd_data = 32'h0;
    case (paddr)
      ADDR_CTRL: begin
        rd_data[CTRL_BYPASS_BIT] = second_pll_bypass_r;
        rd_data[CTRL_BIAS_TYPE_BIT] = bias_type_r;
        rd_data[CTRL_CONT_BIT] = continuous_r;
      end
      ADDR_CHAN_PD: rd_data[NUM_CHAN-1:0] = chan_pd_r;
      ADDR_FUNC_SEL: rd_data[NUM_REF_OUT-1:0] = output_function_select_r;
      ADDR_LINE_BIAS: rd_data[NUM_REF_OUT-1:0] = line_bias_enable_r;
      ADDR_CLK_OUT_CFG: rd_data = clk_out_cfg_r;
      ADDR_REF_OUT_CFG: rd_data = ref_out_cfg_r;
      ADDR_PULSE_CNT: rd_data[7:0] = pulse_cnt_r;
      ADDR_REF_DIV: rd_data[NS_W-1:0] = ref_div_r;
      ADDR_GLOBAL_DLY: rd_data[7:0] = global_dly_r;
      ADDR_REF_COARSE: rd_data[NUM_REF_OUT*DLY3_W-1:0] = ref_coarse_r;
      ADDR_REF_FINE: rd_data[NUM_REF_OUT*DLY3_W-1:0] = ref_fine_r;
      ADDR_CLK_DLY_LO: rd_data = clk_dly_r[31:0];
      ADDR_CLK_DLY_HI: rd_data[CDLY_W-1:0] = clk_dly_r[NUM_CHAN*CDLY_W-1:32];
      ADDR_CLK_DIV: rd_data[NUM_CHAN*CDIV_W-1:0] = clk_div_r;
      ADDR_STATUS: rd_data = {19'h0, remain_r, state_r};
      default: addr_hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle with data and error.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_hit;
      prdata <= rd_en ? rd_data : 32'h0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      second_pll_bypass_r <= 1'b0;
      bias_type_r <= 1'b0;
      continuous_r <= 1'b0;
      chan_pd_r <= '0;
      output_function_select_r <= '0;
      line_bias_enable_r <= '0;
      clk_out_cfg_r <= CLK_OUT_CFG_RST;
      ref_out_cfg_r <= REF_OUT_CFG_RST;
      pulse_cnt_r <= PULSE_CNT_RST;
      ref_div_r <= REF_DIV_RST;
      global_dly_r <= '0;
      ref_coarse_r <= '0;
      ref_fine_r <= '0;
      clk_dly_r <= '0;
      clk_div_r <= {NUM_CHAN{CLK_DIV_RST}};
      release_r <= 1'b0;
      resync_r <= 1'b0;
    end else begin
      release_r <= 1'b0;
      resync_r <= 1'b0;
      if (wr_en) begin
        case (paddr)
          ADDR_CTRL: begin
            second_pll_bypass_r <= pwdata[CTRL_BYPASS_BIT];
            bias_type_r <= pwdata[CTRL_BIAS_TYPE_BIT];
            continuous_r <= pwdata[CTRL_CONT_BIT];
            release_r <= pwdata[CTRL_RELEASE_BIT];
            resync_r <= pwdata[CTRL_RESYNC_BIT];
          end
          ADDR_CHAN_PD: chan_pd_r <= pwdata[NUM_CHAN-1:0];
          ADDR_FUNC_SEL: output_function_select_r <= pwdata[NUM_REF_OUT-1:0];
          ADDR_LINE_BIAS: line_bias_enable_r <= pwdata[NUM_REF_OUT-1:0];
          ADDR_CLK_OUT_CFG: clk_out_cfg_r <= pwdata;
          ADDR_REF_OUT_CFG: ref_out_cfg_r <= {4'h0, pwdata[NUM_REF_OUT*CFG_W-1:0]};
          ADDR_PULSE_CNT: pulse_cnt_r <= pwdata[7:0];
          ADDR_REF_DIV: ref_div_r <= pwdata[NS_W-1:0];
          ADDR_GLOBAL_DLY: global_dly_r <= pwdata[7:0];
          ADDR_REF_COARSE: ref_coarse_r <= pwdata[NUM_REF_OUT*DLY3_W-1:0];
          ADDR_REF_FINE: ref_fine_r <= pwdata[NUM_REF_OUT*DLY3_W-1:0];
          ADDR_CLK_DLY_LO: clk_dly_r[31:0] <= pwdata;
          ADDR_CLK_DLY_HI: clk_dly_r[NUM_CHAN*CDLY_W-1:32] <= pwdata[CDLY_W-1:0];
          ADDR_CLK_DIV: clk_div_r <= pwdata[NUM_CHAN*CDIV_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Delay unit tick
  // ==========================================================================
  logic [3:0] tick_cnt_r;
  logic unit_tick_r;
  logic [3:0] tick_div;
  assign tick_div = second_pll_bypass_r ? VCXO_TICK_DIV : VCO_TICK_DIV;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt_r <= 4'h0;
      unit_tick_r <= 1'b0;
    end else if (tick_cnt_r + 4'h1 >= tick_div) begin
      tick_cnt_r <= 4'h0;
      unit_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 4'h1;
      unit_tick_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Channel clock dividers with start delay
  // ==========================================================================
  logic [CDIV_W-1:0] div_cnt_r [NUM_CHAN];
  logic [CDLY_W-1:0] dly_cnt_r [NUM_CHAN];
  logic [CDLY_W-1:0] dly_applied_r [NUM_CHAN];
  logic [NUM_CHAN-1:0] chan_clk_r;
  logic [NUM_CHAN-1:0] chan_wrap;
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      chan_wrap[c] = unit_tick_r && dly_cnt_r[c] == '0 &&
                     div_cnt_r[c] + 6'h1 >= clk_div_r[c*CDIV_W +: CDIV_W];
    end
  end

  // All channels restart together on resync and each holds off by its own delay in units.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        div_cnt_r[c] <= '0;
        dly_cnt_r[c] <= '0;
        dly_applied_r[c] <= '0;
      end
      chan_clk_r <= '0;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (resync_r) begin
          div_cnt_r[c] <= '0;
          dly_cnt_r[c] <= clk_dly_r[c*CDLY_W +: CDLY_W];
          dly_applied_r[c] <= clk_dly_r[c*CDLY_W +: CDLY_W];
          chan_clk_r[c] <= 1'b0;
        end else if (unit_tick_r) begin
          if (dly_cnt_r[c] != '0) begin
            dly_cnt_r[c] <= dly_cnt_r[c] - 8'h1;
          end else if (chan_wrap[c]) begin
            div_cnt_r[c] <= '0;
            chan_clk_r[c] <= 1'b1;
            if (dly_applied_r[c] != clk_dly_r[c*CDLY_W +: CDLY_W]) begin
              // A new delay only shifts the phase at the period boundary.
              dly_cnt_r[c] <= clk_dly_r[c*CDLY_W +: CDLY_W] - dly_applied_r[c];
              dly_applied_r[c] <= clk_dly_r[c*CDLY_W +: CDLY_W];
              chan_clk_r[c] <= 1'b0;
            end
          end else begin
            div_cnt_r[c] <= div_cnt_r[c] + 6'h1;
            chan_clk_r[c] <= (div_cnt_r[c] + 6'h1) < (clk_div_r[c*CDIV_W +: CDIV_W] >> 1);
          end
        end
      end
    end
  end

  // ==========================================================================
  // SYSREF event state machine
  // ==========================================================================
  logic [8:0] gdly_cnt_r;
  logic [3:0] drain_cnt_r;
  logic [NS_W-1:0] ns_cnt_r;
  logic sr_wave_r;
  logic sr_active;
  logic period_end;
  assign period_end = unit_tick_r && (ns_cnt_r + 13'h1 >= ref_div_r);
  assign sr_active = state_r != SR_IDLE;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= SR_IDLE;
      remain_r <= '0;
      gdly_cnt_r <= '0;
      drain_cnt_r <= '0;
      ns_cnt_r <= '0;
      sr_wave_r <= 1'b0;
    end else begin
      case (state_r)
        SR_IDLE: begin
          sr_wave_r <= 1'b0;
          if (release_r) begin
            state_r <= SR_ARM;
            remain_r <= pulse_cnt_r;
          end
        end
        SR_ARM: begin
          // Start on a channel A boundary so pulses sit on an incident clock edge.
          if (chan_wrap[0]) begin
            state_r <= SR_GDLY;
            gdly_cnt_r <= 9'(global_dly_r) * 9'(GLOBAL_UNITS_PER_STEP);
          end
        end
        SR_GDLY: begin
          if (gdly_cnt_r == '0) begin
            state_r <= SR_RUN;
            ns_cnt_r <= '0;
            sr_wave_r <= continuous_r || remain_r != '0;
          end else if (unit_tick_r) begin
            gdly_cnt_r <= gdly_cnt_r - 9'h1;
          end
        end
        SR_RUN: begin
          if (unit_tick_r) begin
            if (period_end) begin
              ns_cnt_r <= '0;
              if (!continuous_r && remain_r <= 8'h1) begin
                state_r <= SR_DRAIN;
                remain_r <= '0;
                sr_wave_r <= 1'b0;
                drain_cnt_r <= 4'(COARSE_STEPS);
              end else begin
                if (!continuous_r) begin
                  remain_r <= remain_r - 8'h1;
                end
                sr_wave_r <= 1'b1;
              end
            end else begin
              ns_cnt_r <= ns_cnt_r + 13'h1;
              sr_wave_r <= (continuous_r || remain_r != '0) && (ns_cnt_r + 13'h1) < (ref_div_r >> 1);
            end
          end
        end
        SR_DRAIN: begin
          // Let the last pulse leave the coarse delay line before powering down.
          if (drain_cnt_r == '0) begin
            state_r <= SR_IDLE;
          end else if (unit_tick_r) begin
            drain_cnt_r <= drain_cnt_r - 4'h1;
          end
        end
        default: state_r <= SR_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Coarse delay line and output stage
  // ==========================================================================
  logic [COARSE_STEPS-1:0] sr_line_r;
  logic [NUM_REF_OUT*DLY3_W-1:0] coarse_applied_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sr_line_r <= '0;
      coarse_applied_r <= '0;
    end else begin
      if (unit_tick_r) begin
        sr_line_r <= {sr_line_r[COARSE_STEPS-2:0], sr_wave_r};
      end
      if (!sr_active) begin
        coarse_applied_r <= ref_coarse_r;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clock_output <= '0;
    end else begin
      for (int y = 0; y < NUM_CLK_OUT; y++) begin
        clock_output[y].power_on <= !clk_out_cfg_r[y*CFG_W+CFG_PD_BIT] && !chan_pd_r[CLK_CHAN[y]];
        clock_output[y].drive <= clk_out_cfg_r[y*CFG_W+CFG_EN_BIT];
        clock_output[y].data <= clk_out_cfg_r[y*CFG_W+CFG_EN_BIT] && chan_clk_r[CLK_CHAN[y]];
        clock_output[y].mid_bias <= 1'b0;
        clock_output[y].amp <= clk_out_cfg_r[y*CFG_W+CFG_AMP_LSB +: 2];
        clock_output[y].fine <= '0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sysref_output <= '0;
    end else begin
      for (int r = 0; r < NUM_REF_OUT; r++) begin
        sysref_output[r].amp <= ref_out_cfg_r[r*CFG_W+CFG_AMP_LSB +: 2];
        sysref_output[r].drive <= ref_out_cfg_r[r*CFG_W+CFG_EN_BIT];
        if (output_function_select_r[r]) begin
          // Line bias pins the output at rest; style picks low or crosspoint.
          sysref_output[r].power_on <= !chan_pd_r[REF_CHAN[r]] && sr_active && !line_bias_enable_r[r];
          sysref_output[r].mid_bias <= !chan_pd_r[REF_CHAN[r]] && bias_type_r &&
                                       (line_bias_enable_r[r] || !sr_active);
          sysref_output[r].data <= ref_out_cfg_r[r*CFG_W+CFG_EN_BIT] && sr_active && !line_bias_enable_r[r] &&
                                   sr_line_r[coarse_applied_r[r*DLY3_W +: DLY3_W]];
          sysref_output[r].fine <= ref_fine_r[r*DLY3_W +: DLY3_W];
        end else begin
          sysref_output[r].power_on <= !ref_out_cfg_r[r*CFG_W+CFG_PD_BIT] && !chan_pd_r[REF_CHAN[r]];
          sysref_output[r].mid_bias <= 1'b0;
          sysref_output[r].data <= ref_out_cfg_r[r*CFG_W+CFG_EN_BIT] && chan_clk_r[REF_CHAN[r]];
          sysref_output[r].fine <= '0;
        end
      end
    end
  end

endmodule : sysref_out_ctrl

// *** rtl/sysref_out_pkg.sv ***
// Package with register map, field layout, timing constants and carrier types of the output stage control.
package sysref_out_pkg;

  localparam int NUM_CHAN = 5;
  localparam int NUM_CLK_OUT = 8;
  localparam int NUM_REF_OUT = 7;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAN_PD = 8'h04;
  localparam logic [7:0] ADDR_FUNC_SEL = 8'h08;
  localparam logic [7:0] ADDR_LINE_BIAS = 8'h0c;
  localparam logic [7:0] ADDR_CLK_OUT_CFG = 8'h10;
  localparam logic [7:0] ADDR_REF_OUT_CFG = 8'h14;
  localparam logic [7:0] ADDR_PULSE_CNT = 8'h18;
  localparam logic [7:0] ADDR_REF_DIV = 8'h1c;
  localparam logic [7:0] ADDR_GLOBAL_DLY = 8'h20;
  localparam logic [7:0] ADDR_REF_COARSE = 8'h24;
  localparam logic [7:0] ADDR_REF_FINE = 8'h28;
  localparam logic [7:0] ADDR_CLK_DLY_LO = 8'h2c;
  localparam logic [7:0] ADDR_CLK_DLY_HI = 8'h30;
  localparam logic [7:0] ADDR_CLK_DIV = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;

  // Control register bits.
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int CTRL_BIAS_TYPE_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_RELEASE_BIT = 8;
  localparam int CTRL_RESYNC_BIT = 9;

  // Per-output configuration nibble: enable, amplitude, power down.
  localparam int CFG_W = 4;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_AMP_LSB = 1;
  localparam int CFG_PD_BIT = 3;
  localparam int DLY3_W = 3;
  localparam int CDIV_W = 6;
  localparam int CDLY_W = 8;
  localparam int NS_W = 13;

  // Reset values.
  localparam logic [1:0] AMP_500MV = 2'h1;
  localparam logic [31:0] CLK_OUT_CFG_RST = 32'h33333333;
  localparam logic [31:0] REF_OUT_CFG_RST = 32'h03333333;
  localparam logic [CDIV_W-1:0] CLK_DIV_RST = 6'h02;
  localparam logic [NS_W-1:0] REF_DIV_RST = 13'h0080;
  localparam logic [7:0] PULSE_CNT_RST = 8'h01;

  // Delay unit rates: one tick per VCO period, or per VCXO period in bypass.
  localparam logic [3:0] VCO_TICK_DIV = 4'h1;
  localparam logic [3:0] VCXO_TICK_DIV = 4'h8;
  localparam int COARSE_STEPS = 8;
  localparam int GLOBAL_UNITS_PER_STEP = 2;

  // Output slot to channel mapping (A=0 .. E=4).
  localparam logic [2:0] CLK_CHAN [NUM_CLK_OUT] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
  localparam logic [2:0] REF_CHAN [NUM_REF_OUT] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3};

  typedef enum logic [4:0] {
    SR_IDLE = 5'b00001,
    SR_ARM = 5'b00010,
    SR_GDLY = 5'b00100,
    SR_RUN = 5'b01000,
    SR_DRAIN = 5'b10000
  } sr_state_e;

  typedef struct packed {
    logic power_on;
    logic drive;
    logic data;
    logic mid_bias;
    logic [1:0] amp;
    logic [2:0] fine;
  } out_s;

endpackage : sysref_out_pkg

// *** tb/converter_model.sv ***
// Behavioural model of the data converters that receive SYSREF lanes 0 and 1.
`timescale 1ns/10ps
module converter_model
  import sysref_out_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire out_s [NUM_REF_OUT-1:0] sysref_output,
  output logic [7:0] cnt0,
  output logic [7:0] cnt1,
  output logic [7:0] lat
);
  logic [1:0] prev_r;

  // ==========================================================================
  // Edge capture: an unpowered lane delivers no edge to the converter.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clr) begin
      cnt0 <= 8'h00;
      cnt1 <= 8'h00;
      lat <= 8'h00;
      prev_r <= 2'b00;
    end else begin
      prev_r <= {sysref_output[1].data, sysref_output[0].data};
      if (sysref_output[0].power_on && sysref_output[0].data && !prev_r[0]) begin
        cnt0 <= cnt0 + 8'h01;
      end
      if (sysref_output[1].power_on && sysref_output[1].data && !prev_r[1]) begin
        cnt1 <= cnt1 + 8'h01;
      end
      // Cycles from lane power-up to the first captured edge.
      if (sysref_output[0].power_on && cnt0 == 8'h00 && !sysref_output[0].data) begin
        lat <= lat + 8'h01;
      end
    end
  end
endmodule : converter_model

// *** tb/out_stage_checker.sv ***
// Concurrent checks on the ports of the output stage control block.
`timescale 1ns/10ps
module out_stage_checker
  import sysref_out_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire out_s [NUM_CLK_OUT-1:0] clock_output,
  input wire out_s [NUM_REF_OUT-1:0] sysref_output
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Register bus handshake.
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_wait_a: assert property (psel && penable && !pready && !$past(penable) |=> pready)
    else $error("pready not one cycle after the first access cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer cycle");

  // ==========================================================================
  // Output stages.
  clk_fine_zero_a: assert property (clock_output[0].fine == 3'h0 && clock_output[7].fine == 3'h0)
    else $error("clock output carries a fine delay code");
  ref_toggle_on_a: assert property ($rose(sysref_output[0].data) |-> sysref_output[0].power_on)
    else $error("sysref lane toggles while powered off");
  bias_quiet_a: assert property (sysref_output[1].mid_bias |-> !sysref_output[1].data)
    else $error("biased lane shows a waveform");
  amp_after_write_a: assert property ($changed(clock_output[0].amp) && $past(rst_n, 3) |-> $past(pready && pwrite, 2))
    else $error("amplitude changed without a register write");
  drive_after_write_a: assert property ($changed(clock_output[1].drive) && $past(rst_n, 3) |-> $past(pready && pwrite, 2))
    else $error("enable changed without a register write");
  ref_off_low_a: assert property ($fell(sysref_output[0].power_on) |-> !sysref_output[0].data)
    else $error("sysref lane left high at power down");
  clk_data_en_a: assert property (clock_output[0].data |-> clock_output[0].drive)
    else $error("disabled clock output shows a waveform");

  release_c: cover property (pready && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_RELEASE_BIT]);
  ref_on_c: cover property ($rose(sysref_output[0].power_on));
  bus_err_c: cover property (pslverr);
  bias_c: cover property (sysref_output[1].mid_bias);
endmodule : out_stage_checker

bind sysref_out_ctrl out_stage_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clock_output(clock_output), .sysref_output(sysref_output));

// *** tb/testbench.sv ***
// Self-checking bench for the output stage control block.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
  import sysref_out_pkg::*;
;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, clr, err;
  logic [7:0] paddr, cnt0, cnt1, lat, lat0;
  logic [31:0] pwdata, prdata, rv;
  out_s [NUM_CLK_OUT-1:0] clock_output;
  out_s [NUM_REF_OUT-1:0] sysref_output;
  int err_total = 0;
  int checks = 0;

  sysref_out_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_output(clock_output), .sysref_output(sysref_output));
  converter_model conv (.ref_clk(ref_clk), .rst_n(rst_n), .clr(clr), .sysref_output(sysref_output),
    .cnt0(cnt0), .cnt1(cnt1), .lat(lat));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Bus and event tasks.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) err_total++;
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Runs one SYSREF event with the given control bits and waits for idle.
  task automatic ev(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, ADDR_CTRL, c);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    apb(1'b1, ADDR_CTRL, c | 32'h100);
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rv[4:0] !== 5'h01 && n < 500);
    if (rv[4:0] !== 5'h01) err_total++;
    repeat (3) @(posedge ref_clk);
  endtask : ev

  task automatic close_out;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    #900000;
    err_total++;
    close_out;
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CLK_OUT_CFG, 32'h0);
    `CHK(rv, CLK_OUT_CFG_RST)
    apb(1'b0, ADDR_REF_OUT_CFG, 32'h0);
    `CHK(rv, REF_OUT_CFG_RST)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rv[4:0], 5'h01)
    apb(1'b1, 8'h3c, 32'hffff_ffff);
    apb(1'b0, 8'h3c, 32'h0);
    `CHK({err, rv}, {1'b1, 32'h0})
    `CHK(sysref_output[2].power_on, 1'b1)
    apb(1'b1, ADDR_REF_OUT_CFG, 32'h0333_3b33);
    apb(1'b1, ADDR_CLK_OUT_CFG, 32'h3333_3825);
    apb(1'b1, ADDR_CHAN_PD, 32'h10);
    repeat (3) @(posedge ref_clk);
    `CHK(sysref_output[2].power_on, 1'b0)
    `CHK(clock_output[0].amp, 2'h2)
    `CHK(clock_output[1].drive, 1'b0)
    `CHK(clock_output[2].power_on, 1'b0)
    `CHK(clock_output[3].power_on, 1'b1)
    `CHK(clock_output[6].power_on, 1'b0)
    `CHK(clock_output[5].power_on, 1'b1)
    apb(1'b1, ADDR_CHAN_PD, 32'h0);
    apb(1'b1, ADDR_FUNC_SEL, 32'h7f);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ADDR_REF_FINE, 32'(i));
      repeat (3) @(posedge ref_clk);
      `CHK(sysref_output[0].fine, 3'(i))
    end
    `CHK(sysref_output[0].power_on, 1'b0)
    apb(1'b1, ADDR_REF_DIV, 32'h8);
    apb(1'b1, ADDR_PULSE_CNT, 32'h3);
    apb(1'b1, ADDR_LINE_BIAS, 32'h2);
    apb(1'b1, ADDR_GLOBAL_DLY, 32'h2);
    ev(32'h0);
    lat0 = lat;
    `CHK(cnt0, 8'h03)
    `CHK(cnt1, 8'h00)
    `CHK(sysref_output[0].power_on, 1'b0)
    `CHK(sysref_output[0].mid_bias, 1'b0)
    `CHK(sysref_output[1].mid_bias, 1'b0)
    apb(1'b1, ADDR_PULSE_CNT, 32'h1);
    ev(32'h2);
    `CHK(cnt0, 8'h01)
    `CHK(sysref_output[0].mid_bias, 1'b1)
    `CHK(sysref_output[1].mid_bias, 1'b1)
    ev(32'h1);
    `CHK(lat > lat0 + 8'd20, 1'b1)
    close_out;
  end
endmodule : testbench
